// *** core/cdsr_pkg.sv ***
// Package of constants and carriers for the charger status and ident registers
package cdsr_pkg;
	localparam logic [7:0] ADDR_POWER_MGMT_STATUS = 8'h13;
	localparam logic [7:0] ADDR_RESET_PART_IDENT  = 8'h14;
	localparam int         BIT_VREG_ACTIVE        = 7;
	localparam int         BIT_ILIM_ACTIVE        = 6;
	localparam int         BIT_REG_RESET          = 7;
	localparam int         BIT_IDENT_RSVD_ONE     = 2;
	localparam int         ILIM_LSB_MA            = 50;
	localparam int         ILIM_MSB_MA            = 1600;
	localparam int         ILIM_W                 = 6;
	localparam logic [7:0] UNMAPPED_READ          = 8'h00;

	typedef struct packed {
		logic              input_voltage_reg_active;
		logic              input_current_lim_active;
		logic [ILIM_W-1:0] effective_input_current_limit;
	} cdsr_dpm_s;

	typedef enum logic [1:0] {
		CDSR_IDLE  = 2'b00,
		CDSR_RESET = 2'b01
	} cdsr_state_e;

	typedef struct packed {
		cdsr_state_e state;
		logic [7:0]  rdata;
		logic        reset_req;
	} cdsr_state_s;
endpackage

// *** core/cdsr_regs.sv ***
// Status and ident register bank with self-clearing register reset
`timescale 1ns/1ns
module cdsr_regs #(
	parameter logic [2:0] PART_CONFIG_CODE = 3'h5, // Arbitrary value
	parameter logic [1:0] REVISION_CODE    = 2'h2  // Arbitrary value
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic [7:0]          addr_i,
	input  wire logic                wr_i,
	input  wire logic                rd_i,
	input  wire logic [7:0]          wdata_i,
	input  wire cdsr_pkg::cdsr_dpm_s dpm_i,
	input  wire logic                reset_done_i,
	output logic      [7:0]          rdata_o,
	output logic                     reg_reset_o,
	output logic                     timer_reset_o
);

	cdsr_pkg::cdsr_state_s st_ff;

	cdsr_pkg::cdsr_state_s nxt_st;

	logic                  sel_status;

	logic                  sel_ident;

	logic                  rd_status;

	logic                  rd_ident;

	logic                  rd_unmapped;

	logic                  wr_ident;

	logic                  wr_reset_one;

	logic                  in_idle;

	logic                  in_reset;

	logic                  start_reset;

	logic                  finish_reset;

	logic [7:0]            status_val;

	logic [7:0]            ident_val;

	logic [7:0]            read_mux;

	genvar                 gi;

	// Address decode
	always_comb begin
		sel_status = 1'b0;
		sel_ident  = 1'b0;
		if (addr_i == cdsr_pkg::ADDR_POWER_MGMT_STATUS) begin
			sel_status = 1'b1;
		end
		if (addr_i == cdsr_pkg::ADDR_RESET_PART_IDENT) begin
			sel_ident = 1'b1;
		end
	end

	// Strobe qualification
	always_comb begin
		rd_status    = rd_i && sel_status;
		rd_ident     = rd_i && sel_ident;
		rd_unmapped  = rd_i && !sel_status && !sel_ident;
		wr_ident     = wr_i && sel_ident;
		// Only a written 1 starts a reset; 0 is ignored
		wr_reset_one = wr_ident && wdata_i[cdsr_pkg::BIT_REG_RESET];
	end

	// State decode
	always_comb begin
		in_idle  = 1'b0;
		in_reset = 1'b0;
		case (st_ff.state)
			cdsr_pkg::CDSR_IDLE: begin
				in_idle = 1'b1;
			end
			cdsr_pkg::CDSR_RESET: begin
				in_reset = 1'b1;
			end
			default: begin
				in_idle = 1'b0;
			end
		endcase
	end

	// Writes while a reset is pending are dropped, not queued
	always_comb begin
		start_reset  = in_idle && wr_reset_one;
		finish_reset = in_reset && reset_done_i;
	end

	// Status bits pass straight through; sampled only at read time
	always_comb begin
		status_val[cdsr_pkg::BIT_VREG_ACTIVE] = dpm_i.input_voltage_reg_active;
		status_val[cdsr_pkg::BIT_ILIM_ACTIVE] = dpm_i.input_current_lim_active;
	end

	generate
		for (gi = 0; gi < cdsr_pkg::ILIM_W; gi = gi + 1) begin : g_limit
			assign status_val[gi] = dpm_i.effective_input_current_limit[gi];
		end
	endgenerate

	// Ident register fields
	always_comb begin
		ident_val                               = 8'h00;
		ident_val[cdsr_pkg::BIT_REG_RESET]      = st_ff.reset_req;
		ident_val[6]                            = 1'b0;
		ident_val[5:3]                          = PART_CONFIG_CODE;
		ident_val[cdsr_pkg::BIT_IDENT_RSVD_ONE] = 1'b1;
		ident_val[1:0]                          = REVISION_CODE;
	end

	// Read data select
	always_comb begin
		read_mux = cdsr_pkg::UNMAPPED_READ;
		if (rd_status) begin
			read_mux = status_val;
		end
		if (rd_ident) begin
			read_mux = ident_val;
		end
		if (rd_unmapped) begin
			read_mux = cdsr_pkg::UNMAPPED_READ;
		end
	end

	// Next state
	always_comb begin
		nxt_st = st_ff;

		if (rd_i) begin
			nxt_st.rdata = read_mux;
		end

		case (st_ff.state)
			cdsr_pkg::CDSR_IDLE: begin
				if (start_reset) begin
					nxt_st.state     = cdsr_pkg::CDSR_RESET;
					nxt_st.reset_req = 1'b1;
				end
			end
			cdsr_pkg::CDSR_RESET: begin
				if (finish_reset) begin
					nxt_st.state     = cdsr_pkg::CDSR_IDLE;
					nxt_st.reset_req = 1'b0;
				end
			end
			default: begin
				nxt_st.state     = cdsr_pkg::CDSR_IDLE;
				nxt_st.reset_req = 1'b0;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff.state     <= cdsr_pkg::CDSR_IDLE;
			st_ff.rdata     <= 8'h00;
			st_ff.reset_req <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs
	assign rdata_o = st_ff.rdata;

	assign reg_reset_o = st_ff.reset_req;

	// Timer reset shares the request so both always move together
	assign timer_reset_o = st_ff.reset_req;

endmodule

// *** test/cdsr_partner.sv ***
// Chip side that finishes a register reset
`timescale 1ns/1ns
module cdsr_partner (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic req_i,
	output logic      done_o
);
	logic [1:0] cnt_ff;
	// Takes a few cycles so the pending state is visible to reads
	always_ff @(posedge clk_i) begin
		if (rst_i || !req_i) begin
			cnt_ff <= 2'h0;
		end else begin
			cnt_ff <= cnt_ff + 2'h1;
		end
	end
	assign done_o = &cnt_ff;
endmodule

// *** test/cdsr_regs_chk.sv ***
// Assertions on the register bank ports
`timescale 1ns/1ns
module cdsr_chk (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic       reset_done_i,
	input wire logic       reg_reset_o,
	input wire logic       timer_reset_o,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] dpm_i,
	input wire logic [7:0] rdata_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire hit = wr_i && addr_i == 8'h14;
	reset_set_a: assert property (hit && wdata_i[7] && !reg_reset_o |=> reg_reset_o)
		else $error("reset request not raised");
	timer_follow_a: assert property (timer_reset_o == reg_reset_o)
		else $error("timer reset differs");
	reset_clear_a: assert property (reset_done_i && reg_reset_o |=> !reg_reset_o)
		else $error("reset request not cleared");
	zero_write_a: assert property (!reg_reset_o && !(hit && wdata_i[7]) |=> !reg_reset_o)
		else $error("reset request without a written one");
	reserved_one_a: assert property (rd_i && addr_i == 8'h14 |=> rdata_o[2])
		else $error("ident bit 2 not one");
	status_read_a: assert property (rd_i && addr_i == 8'h13 |=> rdata_o == $past(dpm_i))
		else $error("status read mismatch");
	ident_zero_a: assert property (rd_i && addr_i == 8'h14 |=> !rdata_o[6])
		else $error("ident bit 6 not zero");
	c_rst_c: cover property (reg_reset_o ##1 reset_done_i);
	c_rd_c: cover property (rd_i ##1 rdata_o[7]);
	c_wr_c: cover property (hit && !wdata_i[7]);
endmodule

// *** test/tb_cdsr_regs.sv ***
// Bench for the register bank
`timescale 1ns/1ns
module tb_cdsr_regs;
	logic                clk_i = 1'b0;
	logic                rst_i = 1'b1;
	logic                wr_i = 1'b0;
	logic                rd_i = 1'b0;
	logic                done;
	logic                reg_reset_o;
	logic                timer_reset_o;
	logic [7:0]          addr_i = 8'h00;
	logic [7:0]          wdata_i = 8'h00;
	logic [7:0]          rdata_o;
	cdsr_pkg::cdsr_dpm_s dpm_i = '0;
	int                  fail_count = 0;
	int                  checks_done = 0;
	cdsr_regs dut (.clk_i, .rst_i, .addr_i, .wr_i, .rd_i, .wdata_i, .dpm_i,
		.reset_done_i(done), .rdata_o, .reg_reset_o, .timer_reset_o);
	cdsr_partner far (.clk_i, .rst_i, .req_i(reg_reset_o), .done_o(done));
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	task automatic finish_test;
		$display("checks %0d fails %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] e);
		@(negedge clk_i);
		wr_i = w;
		rd_i = !w;
		addr_i = a;
		wdata_i = d;
		@(negedge clk_i);
		wr_i = 1'b0;
		rd_i = 1'b0;
		if (!w) check("rdata", e, rdata_o);
	endtask
	initial begin
		int n;
		repeat (10) @(negedge clk_i);
		rst_i = 1'b0;
		dpm_i = 8'hA1;
		acc(1'b0, 8'h13, 8'h00, 8'hA1);
		dpm_i = 8'h60;
		acc(1'b0, 8'h13, 8'h00, 8'h60);
		acc(1'b0, 8'h14, 8'h00, 8'h2E);
		acc(1'b1, 8'h14, 8'h00, 8'h00);
		check("reg_reset", 8'h00, {7'h00, reg_reset_o});
		acc(1'b0, 8'h14, 8'h00, 8'h2E);
		acc(1'b1, 8'h13, 8'h80, 8'h00);
		check("reg_reset", 8'h00, {7'h00, reg_reset_o});
		acc(1'b1, 8'h14, 8'h80, 8'h00);
		check("reg_reset", 8'h01, {7'h00, reg_reset_o});
		check("timer_reset", 8'h01, {7'h00, timer_reset_o});
		acc(1'b0, 8'h14, 8'h00, 8'hAE);
		n = 0;
		while (reg_reset_o === 1'b1 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		if (n >= 20) begin
			fail_count++;
			$display("unexpected reg_reset timeout exp 0 got 1");
			finish_test();
		end
		check("timer_reset", 8'h00, {7'h00, timer_reset_o});
		acc(1'b0, 8'h14, 8'h00, 8'h2E);
		acc(1'b0, 8'h20, 8'h00, 8'h00);
		acc(1'b1, 8'h14, 8'h80, 8'h00);
		rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		check("reg_reset", 8'h00, {7'h00, reg_reset_o});
		check("rdata", 8'h00, rdata_o);
		acc(1'b0, 8'h14, 8'h00, 8'h2E);
		finish_test();
	end
endmodule
bind cdsr_regs cdsr_chk chk (.*);
